// ---- cpuod_pkg.sv ----
/*
 Package for the opcode decode tail: opcodes, field positions, flag word
 layout, segment codes, state encoding and decode result structs.
 Assumes one 100 MHz clock domain shared with the fetch queue.
*/
package cpuod_pkg;

  // Opcodes
  localparam logic [7:0] OP_JUMP_IF_OVERFLOW = 8'h70;
  localparam logic [7:0] OP_JUMP_IF_NO_OVERFLOW = 8'h71;
  localparam logic [7:0] OP_JUMP_IF_NONZERO = 8'h75;
  localparam logic [7:0] OP_JUMP_SIGNED_NOT_LESS = 8'h7D;
  localparam logic [7:0] OP_JUMP_SIGNED_GREATER = 8'h7F;
  localparam logic [7:0] OP_JUMP_UNSIGNED_NOT_BELOW = 8'h73;
  localparam logic [7:0] OP_JUMP_UNSIGNED_ABOVE = 8'h77;
  localparam logic [7:0] OP_COUNT_LOOP = 8'hE2;
  localparam logic [7:0] OP_COUNT_LOOP_WHILE_ZERO = 8'hE1;
  localparam logic [7:0] OP_COUNT_LOOP_WHILE_NONZERO = 8'hE0;
  localparam logic [7:0] OP_JUMP_IF_COUNT_ZERO = 8'hE3;
  localparam logic [7:0] OP_TRAP_TYPED = 8'hCD;
  localparam logic [7:0] OP_TRAP_BREAK = 8'hCC;
  localparam logic [7:0] OP_TRAP_ON_OVERFLOW = 8'hCE;
  localparam logic [7:0] OP_TRAP_RETURN = 8'hCF;
  localparam logic [7:0] OP_CARRY_CLEAR = 8'hF8;
  localparam logic [7:0] OP_CARRY_TOGGLE = 8'hF5;
  localparam logic [7:0] OP_CARRY_SET = 8'hF9;
  localparam logic [7:0] OP_DIRECTION_CLEAR = 8'hFC;
  localparam logic [7:0] OP_DIRECTION_SET = 8'hFD;
  localparam logic [7:0] OP_IRQ_ENABLE_CLEAR = 8'hFA;
  localparam logic [7:0] OP_IRQ_ENABLE_SET = 8'hFB;
  localparam logic [4:0] OP_EXTERNAL_ESCAPE_HI = 5'h1B;
  localparam logic [7:0] OP_BUS_LOCK = 8'hF0;
  localparam logic [2:0] SEG_PREFIX_HI = 3'h1;
  localparam logic [2:0] SEG_PREFIX_LO = 3'h6;
  localparam logic [7:0] BREAK_VECTOR = 8'h03;
  localparam logic [7:0] OVERFLOW_VECTOR = 8'h04;

  // Operand fields
  localparam int DIR_BIT = 1;
  localparam int WIDTH_BIT = 0;
  localparam int SIGN_BIT = 1;
  localparam int COUNT_SRC_BIT = 1;
  localparam logic [1:0] MODE_NO_DISP = 2'h0;
  localparam logic [1:0] MODE_DISP8 = 2'h1;
  localparam logic [1:0] MODE_DISP16 = 2'h2;
  localparam logic [1:0] MODE_REGISTER = 2'h3;
  localparam logic [2:0] RM_DIRECT = 3'h6;
  localparam logic [1:0] SW_WORD_IMM = 2'h1;
  localparam logic [1:0] SW_SIGNED_BYTE = 2'h3;

  // Segment codes
  localparam logic [1:0] SEG_EXTRA = 2'h0;
  localparam logic [1:0] SEG_CODE = 2'h1;
  localparam logic [1:0] SEG_STACK = 2'h2;
  localparam logic [1:0] SEG_DATA = 2'h3;

  // Flag word bit positions
  localparam int FLAG_OVERFLOW = 11;
  localparam int FLAG_DIRECTION = 10;
  localparam int FLAG_IRQ_ENABLE = 9;
  localparam int FLAG_TRAP = 8;
  localparam int FLAG_SIGN = 7;
  localparam int FLAG_ZERO = 6;
  localparam int FLAG_AUX_CARRY = 4;
  localparam int FLAG_PARITY = 2;
  localparam int FLAG_CARRY = 0;
  localparam logic [15:0] FLAG_USED_MASK = 16'h0FD5;
  localparam logic [15:0] FLAG_RESET = 16'h0000;

  typedef enum logic [1:0] {
    CPUOD_OPCODE = 2'b00,
    CPUOD_OPERAND = 2'b01,
    CPUOD_DISP_HIGH = 2'b11
  } cpuod_state_type;

  // Effective address inputs
  typedef struct packed {
    logic [15:0] b_base_register;
    logic [15:0] frame_base_register;
    logic [15:0] source_index_register;
    logic [15:0] destination_index_register;
  } cpuod_regs_type;

  // Decode of the operand byte and operand fields
  typedef struct packed {
    logic reg_is_dest;
    logic word_op;
    logic operand_is_reg;
    logic [1:0] disp_bytes;
    logic [15:0] effective_address;
    logic [15:0] imm_signed_byte;
    logic imm_word;
    logic [7:0] shift_count;
  } cpuod_fields_type;

  // Branch and trap result
  typedef struct packed {
    logic branch;
    logic [15:0] next_ip;
    logic trap;
    logic [7:0] trap_vector;
    logic trap_return;
    logic escape;
    logic bus_lock;
    logic seg_override;
    logic [1:0] segment;
  } cpuod_result_type;

endpackage

// ---- cpuod_decode.sv ----
/*
 Opcode decode tail: conditional short jumps, count loops, software traps,
 trap return, flag control, escape, bus lock, segment prefix and the
 shared operand fields with effective address formation.
 Assumes the fetch queue hands one byte per cycle with a valid strobe,
 already in the clock domain, and that the core supplies register values.
*/
`timescale 1ns/10ps
module cpuod_decode
  import cpuod_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fetch queue
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic [15:0] ip_of_byte,
  // Core state
  input wire logic [15:0] count_register,
  input wire cpuod_pkg::cpuod_regs_type regs,
  input wire logic [7:0] op_byte,
  // Flag word port
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // Results
  output logic [15:0] processor_flag_word,
  output cpuod_pkg::cpuod_fields_type fields,
  output cpuod_pkg::cpuod_result_type result,
  output logic result_valid,
  output logic count_decrement
);
  import cpuod_pkg::*;

  function automatic logic [15:0] sext8(input logic [7:0] b);
    sext8 = {{8{b[7]}}, b};
  endfunction

  cpuod_state_type state;
  logic [7:0] opcode;
  logic lock_pending;
  logic seg_pending;
  logic [1:0] seg_code;

  // Byte classification
  wire is_opcode = byte_valid && state == CPUOD_OPCODE;
  wire is_operand = byte_valid && state == CPUOD_OPERAND;
  wire short_jump = byte_data[7:4] == 4'h7 || byte_data[7:2] == 6'h38;
  wire escape_op = byte_data[7:3] == OP_EXTERNAL_ESCAPE_HI;
  wire needs_operand = short_jump || escape_op
    || byte_data == OP_TRAP_TYPED;
  wire seg_prefix = byte_data[7:5] == SEG_PREFIX_HI
    && byte_data[2:0] == SEG_PREFIX_LO;
  wire lock_prefix = byte_data == OP_BUS_LOCK;
  wire single_done = is_opcode && !needs_operand && !seg_prefix
    && !lock_prefix;

  // Flag views
  wire f_of = processor_flag_word[FLAG_OVERFLOW];
  wire f_zf = processor_flag_word[FLAG_ZERO];
  wire f_sf = processor_flag_word[FLAG_SIGN];
  wire f_cf = processor_flag_word[FLAG_CARRY];
  wire [15:0] count_after = count_register - 16'h0001;
  wire loop_more = count_after != 16'h0000;

  // Condition for the buffered opcode
  logic cond;
  always_comb
  begin
    case (opcode)
      OP_JUMP_IF_OVERFLOW: cond = f_of;
      OP_JUMP_IF_NO_OVERFLOW: cond = !f_of;
      OP_JUMP_IF_NONZERO: cond = !f_zf;
      OP_JUMP_SIGNED_NOT_LESS: cond = f_sf == f_of;
      OP_JUMP_SIGNED_GREATER: cond = !f_zf && f_sf == f_of;
      OP_JUMP_UNSIGNED_NOT_BELOW: cond = !f_cf;
      OP_JUMP_UNSIGNED_ABOVE: cond = !f_cf && !f_zf;
      OP_COUNT_LOOP: cond = loop_more;
      OP_COUNT_LOOP_WHILE_ZERO: cond = loop_more && f_zf;
      OP_COUNT_LOOP_WHILE_NONZERO: cond = loop_more && !f_zf;
      OP_JUMP_IF_COUNT_ZERO: cond = count_register == 16'h0000;
      default: cond = 1'b0;
    endcase
  end

  // Other jump conditions in the family are left to neighbouring logic
  wire is_loop = opcode[7:2] == 6'h38 && opcode != OP_JUMP_IF_COUNT_ZERO;
  wire [15:0] fallthrough = ip_of_byte + 16'h0001;
  wire [15:0] jump_target = fallthrough + sext8(byte_data);

  // Fields decode op_byte; the core puts a wide displacement on wdata
  wire [1:0] f_mode = op_byte[7:6];
  wire [2:0] f_rm = op_byte[2:0];
  logic [15:0] f_base;
  always_comb
  begin
    case (f_rm)
      3'h0: f_base = regs.b_base_register + regs.source_index_register;
      3'h1: f_base = regs.b_base_register + regs.destination_index_register;
      3'h2: f_base = regs.frame_base_register + regs.source_index_register;
      3'h3: f_base = regs.frame_base_register
        + regs.destination_index_register;
      3'h4: f_base = regs.source_index_register;
      3'h5: f_base = regs.destination_index_register;
      3'h6: f_base = regs.frame_base_register;
      default: f_base = regs.b_base_register;
    endcase
  end
  wire f_direct = f_mode == MODE_NO_DISP && f_rm == RM_DIRECT;
  logic [15:0] f_disp;
  always_comb
  begin
    case (f_mode)
      MODE_DISP8: f_disp = sext8(byte_data);
      MODE_DISP16: f_disp = wdata;
      default: f_disp = f_direct ? wdata : 16'h0000;
    endcase
  end

  always_comb
  begin
    fields.reg_is_dest = opcode[DIR_BIT];
    fields.word_op = opcode[WIDTH_BIT];
    fields.operand_is_reg = f_mode == MODE_REGISTER;
    fields.disp_bytes = f_direct ? 2'h2
      : (f_mode == MODE_REGISTER ? 2'h0 : f_mode);
    fields.effective_address = f_direct ? f_disp
      : f_base + f_disp;
    fields.imm_signed_byte = sext8(byte_data);
    fields.imm_word = opcode[SIGN_BIT:WIDTH_BIT] == SW_WORD_IMM;
    fields.shift_count = opcode[COUNT_SRC_BIT] ? count_register[7:0]
      : 8'h01;
  end

  // Sequencing
  cpuod_state_type next_state;
  always_comb
  begin
    case (state)
      CPUOD_OPCODE: next_state = (is_opcode && needs_operand)
        ? CPUOD_OPERAND : CPUOD_OPCODE;
      CPUOD_OPERAND: next_state = CPUOD_OPCODE;
      CPUOD_DISP_HIGH: next_state = byte_valid ? CPUOD_OPCODE
        : CPUOD_DISP_HIGH;
      default: next_state = CPUOD_OPCODE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state <= CPUOD_OPCODE;
    else if (byte_valid)
      state <= next_state;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      opcode <= 8'h00;
    else if (is_opcode)
      opcode <= byte_data;
  end

  // Prefixes hold until the next full instruction completes
  wire instr_done = single_done || is_operand;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lock_pending <= 1'b0;
      seg_pending <= 1'b0;
      seg_code <= SEG_EXTRA;
    end
    else if (is_opcode && lock_prefix)
      lock_pending <= 1'b1;
    else if (is_opcode && seg_prefix)
    begin
      seg_pending <= 1'b1;
      seg_code <= byte_data[4:3];
    end
    else if (instr_done)
    begin
      lock_pending <= 1'b0;
      seg_pending <= 1'b0;
    end
  end

  // Result staging, one cycle after the last byte
  cpuod_result_type next_result;
  always_comb
  begin
    next_result = '0;
    next_result.bus_lock = lock_pending;
    next_result.seg_override = seg_pending;
    next_result.segment = seg_code;
    next_result.next_ip = fallthrough;
    if (is_operand)
    begin
      if (opcode == OP_TRAP_TYPED)
      begin
        next_result.trap = 1'b1;
        next_result.trap_vector = byte_data;
      end
      else if (opcode[7:3] == OP_EXTERNAL_ESCAPE_HI)
        next_result.escape = 1'b1;
      else
      begin
        next_result.branch = cond;
        next_result.next_ip = cond ? jump_target : fallthrough;
      end
    end
    else if (byte_data == OP_TRAP_BREAK)
    begin
      next_result.trap = 1'b1;
      next_result.trap_vector = BREAK_VECTOR;
    end
    else if (byte_data == OP_TRAP_ON_OVERFLOW)
    begin
      next_result.trap = f_of;
      next_result.trap_vector = OVERFLOW_VECTOR;
    end
    else if (byte_data == OP_TRAP_RETURN)
      next_result.trap_return = 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      result <= '0;
      result_valid <= 1'b0;
      count_decrement <= 1'b0;
    end
    else
    begin
      result_valid <= instr_done;
      count_decrement <= is_operand && is_loop;
      if (instr_done)
        result <= next_result;
    end
  end

  // Flag word: opcode effects win over a port write in the same cycle
  logic [15:0] next_flags;
  always_comb
  begin
    next_flags = processor_flag_word;
    if (wr)
      next_flags = wdata & FLAG_USED_MASK;
    if (single_done)
    begin
      case (byte_data)
        OP_CARRY_CLEAR: next_flags[FLAG_CARRY] = 1'b0;
        OP_CARRY_TOGGLE: next_flags[FLAG_CARRY] = !f_cf;
        OP_CARRY_SET: next_flags[FLAG_CARRY] = 1'b1;
        OP_DIRECTION_CLEAR: next_flags[FLAG_DIRECTION] = 1'b0;
        OP_DIRECTION_SET: next_flags[FLAG_DIRECTION] = 1'b1;
        OP_IRQ_ENABLE_CLEAR: next_flags[FLAG_IRQ_ENABLE] = 1'b0;
        OP_IRQ_ENABLE_SET: next_flags[FLAG_IRQ_ENABLE] = 1'b1;
        default: next_flags = next_flags;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      processor_flag_word <= FLAG_RESET;
    else
      processor_flag_word <= next_flags;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata <= 16'h0000;
    else if (rd)
      rdata <= processor_flag_word;
    else
      rdata <= 16'h0000;
  end

  // Assertions
  a_carry_clear: assert property (@(posedge clk) disable iff (rst)
    single_done && byte_data == OP_CARRY_CLEAR |=> !f_cf)
    else $error("carry not cleared");
  a_carry_toggle: assert property (@(posedge clk) disable iff (rst)
    single_done && byte_data == OP_CARRY_TOGGLE
    |=> f_cf != $past(f_cf))
    else $error("carry not toggled");
  a_dir_set: assert property (@(posedge clk) disable iff (rst)
    single_done && byte_data == OP_DIRECTION_SET
    |=> processor_flag_word[FLAG_DIRECTION])
    else $error("direction not set");
  a_irq_clear: assert property (@(posedge clk) disable iff (rst)
    single_done && byte_data == OP_IRQ_ENABLE_CLEAR
    |=> !processor_flag_word[FLAG_IRQ_ENABLE])
    else $error("irq enable not cleared");
  a_break_vector: assert property (@(posedge clk) disable iff (rst)
    single_done && byte_data == OP_TRAP_BREAK
    |=> result_valid && result.trap
    && result.trap_vector == BREAK_VECTOR)
    else $error("break vector wrong");
  a_trap_return: assert property (@(posedge clk) disable iff (rst)
    single_done && byte_data == OP_TRAP_RETURN
    |=> result.trap_return)
    else $error("trap return missing");
  a_overflow_jump: assert property (@(posedge clk) disable iff (rst)
    is_operand && opcode == OP_JUMP_IF_OVERFLOW
    |=> result.branch == $past(f_of))
    else $error("overflow jump wrong");
  a_nonzero_jump: assert property (@(posedge clk) disable iff (rst)
    is_operand && opcode == OP_JUMP_IF_NONZERO
    |=> result.branch == !$past(f_zf))
    else $error("nonzero jump wrong");
  a_count_zero: assert property (@(posedge clk) disable iff (rst)
    is_operand && opcode == OP_JUMP_IF_COUNT_ZERO
    |=> result.branch == ($past(count_register) == 16'h0000))
    else $error("count zero jump wrong");
  a_jump_target: assert property (@(posedge clk) disable iff (rst)
    is_operand && cond && opcode[7:4] == 4'h7
    |=> result.next_ip == $past(jump_target))
    else $error("jump target wrong");
  a_flags_unused: assert property (@(posedge clk) disable iff (rst)
    (processor_flag_word & ~FLAG_USED_MASK) == 16'h0000)
    else $error("unused flag bit set");
  a_lock_held: assert property (@(posedge clk) disable iff (rst)
    is_opcode && lock_prefix ##1 single_done |=> result.bus_lock)
    else $error("lock lost");
  a_escape_seen: assert property (@(posedge clk) disable iff (rst)
    is_operand && opcode[7:3] == OP_EXTERNAL_ESCAPE_HI
    |=> result_valid && result.escape)
    else $error("escape not reported");
  a_loop_decrement: assert property (@(posedge clk) disable iff (rst)
    is_operand && opcode == OP_COUNT_LOOP |=> count_decrement)
    else $error("loop count not decremented");

  c_taken_jump: cover property (@(posedge clk) disable iff (rst)
    result_valid && result.branch);
  c_loop: cover property (@(posedge clk) disable iff (rst)
    count_decrement);
  c_seg_override: cover property (@(posedge clk) disable iff (rst)
    result_valid && result.seg_override);
  c_typed_trap: cover property (@(posedge clk) disable iff (rst)
    result_valid && result.trap && result.trap_vector != BREAK_VECTOR);
endmodule

// ---- cpuod_fetch_model.sv ----
/*
 Fetch queue model: hands opcode and operand bytes to the decoder.
 Assumes the bench calls put and idle from one process, after an edge.
*/
`timescale 1ns/10ps
module cpuod_fetch_model
(
  // Clock
  input wire logic clk,
  // Byte stream
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic [15:0] ip_of_byte
);
  logic [15:0] ip_next;

  initial
  begin
    byte_valid = 1'b0;
    byte_data = 8'h5A;
    ip_of_byte = 16'h0000;
    ip_next = 16'h1000;
  end

  // One byte per edge, addresses run on
  task automatic put(input logic [7:0] b);
    @(posedge clk);
    byte_valid <= 1'b1;
    byte_data <= b;
    ip_of_byte <= ip_next;
    ip_next = ip_next + 16'h0001;
  endtask

  // Released lines change, so a stale byte cannot pass for a fresh one
  task automatic idle();
    @(posedge clk);
    byte_valid <= 1'b0;
    byte_data <= ~byte_data;
    ip_of_byte <= ~ip_of_byte;
  endtask
endmodule

// ---- cpu_opcode_decode_tail_tb.sv ----
/*
 Self-checking bench for the opcode decode tail.
 Assumes the fetch queue model beside it and a 100 MHz clock.
*/
`timescale 1ns/10ps
module cpu_opcode_decode_tail_tb;
  import cpuod_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic byte_valid;
  logic [7:0] byte_data;
  logic [15:0] ip_of_byte;
  logic [15:0] count_register = 16'h0000;
  cpuod_regs_type regs = {16'h1000, 16'h2000, 16'h0030, 16'h0400};
  logic [7:0] op_byte = 8'h00;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [15:0] processor_flag_word;
  cpuod_fields_type fields;
  cpuod_result_type result;
  logic result_valid;
  logic count_decrement;
  logic [15:0] fl;
  int n_fail = 0;
  int checks_done = 0;
  // Opcode, flags, count, taken
  localparam logic [32:0] BR [22] = '{
    {8'h70,16'h0800,8'h00,1'b1}, {8'h70,16'h0000,8'h00,1'b0},
    {8'h71,16'h0000,8'h00,1'b1}, {8'h71,16'h0800,8'h00,1'b0},
    {8'h75,16'h0000,8'h00,1'b1}, {8'h75,16'h0040,8'h00,1'b0},
    {8'h7D,16'h0880,8'h00,1'b1}, {8'h7D,16'h0080,8'h00,1'b0},
    {8'h7F,16'h0880,8'h00,1'b1}, {8'h7F,16'h0840,8'h00,1'b0},
    {8'h73,16'h0000,8'h00,1'b1}, {8'h73,16'h0001,8'h00,1'b0},
    {8'h77,16'h0000,8'h00,1'b1}, {8'h77,16'h0040,8'h00,1'b0},
    {8'hE2,16'h0000,8'h05,1'b1}, {8'hE2,16'h0000,8'h01,1'b0},
    {8'hE1,16'h0040,8'h05,1'b1}, {8'hE1,16'h0000,8'h05,1'b0},
    {8'hE0,16'h0000,8'h05,1'b1}, {8'hE0,16'h0040,8'h05,1'b0},
    {8'hE3,16'h0000,8'h00,1'b1}, {8'hE3,16'h0000,8'h01,1'b0}};
  // Operand byte, effective address, displacement bytes
  localparam logic [25:0] EA [11] = '{
    {8'hA8,16'h2320,2'h2}, {8'hA9,16'h26F0,2'h2}, {8'hAA,16'h3320,2'h2},
    {8'hAB,16'h36F0,2'h2}, {8'hAC,16'h1320,2'h2}, {8'hAD,16'h16F0,2'h2},
    {8'hAE,16'h32F0,2'h2}, {8'hAF,16'h22F0,2'h2}, {8'h47,16'h0FF0,2'h1},
    {8'h06,16'h12F0,2'h2}, {8'h04,16'h0030,2'h0}};

  always #5 clk = ~clk;

  cpuod_fetch_model fm (.clk(clk), .byte_valid(byte_valid),
    .byte_data(byte_data), .ip_of_byte(ip_of_byte));

  cpuod_decode dut (.clk(clk), .rst(rst), .byte_valid(byte_valid),
    .byte_data(byte_data), .ip_of_byte(ip_of_byte),
    .count_register(count_register), .regs(regs), .op_byte(op_byte),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .processor_flag_word(processor_flag_word), .fields(fields),
    .result(result), .result_valid(result_valid),
    .count_decrement(count_decrement));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("Mismatches %0d in %0d checks", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wr_flags(input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    fl = v & FLAG_USED_MASK;
  endtask

  task automatic rd_flags(input logic [15:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, fl);
  endtask

  // Bounded wait, the result pulse lasts one cycle only
  task automatic wait_res();
    int i;
    i = 0;
    fm.idle();
    #1;
    while (result_valid !== 1'b1 && i < 4)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    chk(result_valid, 1'b1);
  endtask

  task automatic branch_case(input logic [32:0] e);
    logic [15:0] nip;
    logic [7:0] d;
    d = e[32] ? 8'h12 : 8'hF0;
    wr_flags(e[24:9]);
    count_register <= {8'h00, e[8:1]};
    fm.put(e[32:25]);
    fm.put(d);
    nip = fm.ip_next;
    if (e[0])
      nip = nip + {{8{d[7]}}, d};
    wait_res();
    chk(result.branch, e[0]);
    chk(result.next_ip, nip);
    chk(count_decrement, e[32:27] == 6'h38 && e[26:25] != 2'h3);
  endtask

  task automatic trap_case(input logic [7:0] op, input logic two,
    input logic [7:0] arg, input logic [15:0] f, input logic [9:0] exp);
    wr_flags(f);
    fm.put(op);
    if (two)
    begin
      fm.idle();
      fm.put(arg);
    end
    wait_res();
    chk({result.trap_return, result.trap}, exp[9:8]);
    if (exp[8])
      chk(result.trap_vector, exp[7:0]);
  endtask

  task automatic flag_ops();
    logic [7:0] ops [9];
    ops = '{8'hF9, 8'hF5, 8'hF5, 8'hF8, 8'hFD, 8'hFC, 8'hFB, 8'hFA, 8'hFB};
    wr_flags(16'h0000);
    foreach (ops[i])
    begin
      fm.put(ops[i]);
      case (ops[i])
        OP_CARRY_CLEAR: fl[FLAG_CARRY] = 1'b0;
        OP_CARRY_TOGGLE: fl[FLAG_CARRY] = ~fl[FLAG_CARRY];
        OP_CARRY_SET: fl[FLAG_CARRY] = 1'b1;
        OP_DIRECTION_CLEAR: fl[FLAG_DIRECTION] = 1'b0;
        OP_DIRECTION_SET: fl[FLAG_DIRECTION] = 1'b1;
        OP_IRQ_ENABLE_CLEAR: fl[FLAG_IRQ_ENABLE] = 1'b0;
        default: fl[FLAG_IRQ_ENABLE] = 1'b1;
      endcase
      wait_res();
      chk(processor_flag_word, fl);
    end
    rd_flags(16'h0000);
  endtask

  task automatic prefix_cases();
    fm.put(OP_BUS_LOCK);
    fm.put(OP_CARRY_SET);
    wait_res();
    chk(result.bus_lock, 1'b1);
    fm.put(OP_CARRY_CLEAR);
    wait_res();
    chk(result.bus_lock, 1'b0);
    for (int s = 0; s < 4; s++)
    begin
      fm.put({SEG_PREFIX_HI, s[1:0], SEG_PREFIX_LO});
      fm.put(OP_CARRY_SET);
      wait_res();
      chk({result.seg_override, result.segment}, {1'b1, s[1:0]});
    end
    for (int k = 0; k < 8; k += 7)
    begin
      fm.put({OP_EXTERNAL_ESCAPE_HI, k[2:0]});
      fm.put(8'h3F);
      wait_res();
      chk(result.escape, 1'b1);
    end
  endtask

  task automatic field_cases();
    fm.put(OP_IRQ_ENABLE_SET);
    wait_res();
    @(posedge clk);
    op_byte <= 8'hC0;
    wdata <= 16'h12F0;
    count_register <= 16'h1237;
    #1;
    chk({fields.reg_is_dest, fields.word_op}, 2'h3);
    chk(fields.operand_is_reg, 1'b1);
    chk(fields.imm_word, 1'b0);
    chk(fields.shift_count, 8'h37);
    fm.put(OP_CARRY_CLEAR);
    wait_res();
    chk({fields.reg_is_dest, fields.word_op}, 2'h0);
    chk(fields.shift_count, 8'h01);
    fm.put(OP_DIRECTION_SET);
    wait_res();
    chk(fields.imm_word, 1'b1);
    // Undecoded byte; the idle model then leaves F0h as the short disp
    fm.put(8'h0F);
    wait_res();
    chk(fields.imm_signed_byte, 16'hFFF0);
    foreach (EA[i])
    begin
      @(posedge clk);
      op_byte <= EA[i][25:18];
      #1;
      chk(fields.effective_address, EA[i][17:2]);
      chk(fields.disp_bytes, EA[i][1:0]);
      chk(fields.operand_is_reg, 1'b0);
    end
  endtask

  initial
  begin
    fl = FLAG_RESET;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(result_valid, 1'b0);
    chk(processor_flag_word, FLAG_RESET);
    rd_flags(16'h0002);
    wr_flags(16'hFFFF);
    rd_flags(16'h0000);
    flag_ops();
    foreach (BR[i])
      branch_case(BR[i]);
    trap_case(OP_TRAP_TYPED, 1'b1, 8'h21, 16'h0000, 10'h121);
    trap_case(OP_TRAP_BREAK, 1'b0, 8'h00, 16'h0000, 10'h103);
    trap_case(OP_TRAP_ON_OVERFLOW, 1'b0, 8'h00, 16'h0800, 10'h104);
    trap_case(OP_TRAP_ON_OVERFLOW, 1'b0, 8'h00, 16'h0000, 10'h000);
    trap_case(OP_TRAP_RETURN, 1'b0, 8'h00, 16'h0000, 10'h200);
    prefix_cases();
    field_cases();
    stop_test();
  end

  // Whole run needs well under 1000 cycles
  initial
  begin
    #50us;
    n_fail++;
    stop_test();
  end
endmodule
